//--- verilog/e1_perf_pkg.sv
package e1_perf_pkg;

  // Register offsets on the parallel control port
  localparam logic [7:0] ADDR_VIOL_HI  = 8'h00;
  localparam logic [7:0] ADDR_VIOL_LO  = 8'h01;
  localparam logic [7:0] ADDR_CRC_HI   = 8'h02;
  localparam logic [7:0] ADDR_CRC_LO   = 8'h03;
  localparam logic [7:0] ADDR_EBIT_HI  = 8'h04;
  localparam logic [7:0] ADDR_EBIT_LO  = 8'h05;
  localparam logic [7:0] ADDR_ALARM    = 8'h06;
  localparam logic [7:0] ADDR_EVENT    = 8'h07;
  localparam logic [7:0] ADDR_ALARM_IM = 8'h16;
  localparam logic [7:0] ADDR_EVENT_IM = 8'h17;

  // Reset values
  localparam logic [7:0] MASK_RESET  = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Counter widths and their saturation values
  localparam int VIOL_W = 16;
  localparam int CRC_W  = 10;
  localparam int EBIT_W = 10;
  localparam int FAS_W  = 12;
  localparam logic [15:0] VIOL_MAX = 16'hffff;
  localparam logic [9:0]  CRC_MAX  = 10'h3ff;
  localparam logic [9:0]  EBIT_MAX = 10'h3ff;
  localparam logic [11:0] FAS_MAX  = 12'hfff;

  // Interval timer, counted in received 125 us frames
  localparam logic [12:0] FRAMES_PER_SECOND = 13'h1f40;  // 8000 frames
  localparam logic [12:0] FRAMES_PER_SHORT  = 13'h01f4;  // 500 frames, 62.5 ms
  localparam logic [3:0]  FRAMES_PER_MF     = 4'hf;      // Last frame of 16, 2 ms

  // Transmit clock watchdog: one channel time
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TX_LOSS_TIME_NS = 3900;
  localparam int TX_LOSS_CYC_INT = (TX_LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] TX_LOSS_CYCLES = TX_LOSS_CYC_INT[8:0];

  // Second status register, bit 7 down to bit 0
  typedef struct packed {
    logic rx_cas_multiframe_flag;
    logic rx_align_frame_flag;
    logic tx_multiframe_flag;
    logic interval_timer_flag;
    logic tx_align_frame_flag;
    logic tx_clock_loss_flag;
    logic rx_crc_multiframe_flag;
    logic tx_slip_flag;
  } sr2_t;

  // First status register, levels from the framer
  typedef struct packed {
    logic rx_sig_all_ones_flag;
    logic rx_distant_mf_alarm_flag;
    logic rx_sig_all_zeros_flag;
    logic rx_slip_flag;
    logic rx_unframed_ones_flag;
    logic rx_remote_alarm_flag;
    logic rx_carrier_loss_flag;
    logic rx_sync_loss_flag;
  } sr1_t;

  // Framer boundary strobes, one-cycle pulses
  typedef struct packed {
    logic rx_cas_mf;
    logic rx_align;
    logic tx_mf;
    logic tx_align;
    logic rx_crc_mf;
    logic tx_slip;
    logic rx_frame;
  } frame_ev_t;

  // Error strobes, one-cycle pulses
  typedef struct packed {
    logic bpv;
    logic hdb3_codeword;
    logic code_viol;
    logic crc_err;
    logic ebit_strobe;
    logic ebit_value;
    logic fas_err;
  } err_ev_t;

  // Synchroniser state, levels
  typedef struct packed {
    logic fas_loss;
    logic crc_loss;
    logic fas_search;
    logic cas_search;
    logic crc_search;
  } sync_t;

endpackage

//--- verilog/e1_status_perf.sv
`timescale 1ns/1ps

module e1_status_perf (
  input  wire logic                   CLK_SYS,
  input  wire logic                   NRST,
  input  wire logic                   CS_N,
  input  wire logic                   RD_N,
  input  wire logic                   WR_N,
  input  wire logic [7:0]             ADDR,
  input  wire logic [7:0]             DATA_IN,
  output logic      [7:0]             DATA_OUT,
  output logic                        DATA_OE_N,
  input  wire logic                   TRANSMIT_CLOCK_IN,
  input  wire e1_perf_pkg::frame_ev_t FRAME_EV,
  input  wire e1_perf_pkg::err_ev_t   ERR_EV,
  input  wire e1_perf_pkg::sync_t     SYNC_STATE,
  input  wire e1_perf_pkg::sr1_t      ALARM_STATUS,
  input  wire logic                   CRC4_ENABLE,
  input  wire logic                   SHORT_INTERVAL_SELECT,
  input  wire logic                   VIOLATION_TYPE_SELECT,
  input  wire logic                   RX_HDB3_ENABLE,
  input  wire logic                   CLOCK_LOSS_PIN_ENABLE,
  output logic                        TX_CLOCK_LOSS,
  output logic                        INT_REQ
);
  import e1_perf_pkg::*;

  // Host port synchronisers; strobes and buses settle long before use
  logic [18:0] bus_s1_q;
  logic [18:0] bus_s2_q;
  logic        rd_prev_q;
  logic        wr_prev_q;
  logic        rd_event_q;
  sr2_t        rd_snap_q;
  logic [7:0]  alarm_interrupt_mask_q;
  sr2_t        event_interrupt_mask_q;
  sr2_t        sr2_q;
  logic [2:0]  transmit_clock_in_q;
  logic [8:0]  loss_cnt_q;
  logic [12:0] frame_cnt_q;
  logic [3:0]  mf_cnt_q;
  logic [15:0] viol_acc_q;
  logic [9:0]  crc_acc_q;
  logic [9:0]  ebit_acc_q;
  logic [11:0] fas_acc_q;
  logic [15:0] viol_q;
  logic [9:0]  crc_q;
  logic [9:0]  ebit_q;
  logic [11:0] fas_q;
  logic [7:0]  addr_s;
  logic [7:0]  din_s;
  logic        rd_act;
  logic        wr_act;
  logic        transmit_clock_in_edge;
  logic        clock_lost;
  logic        interval_tick;
  logic [12:0] frame_limit;
  logic        crc_mf_evt;
  logic        viol_inc;
  logic        crc_inc;
  logic        ebit_inc;
  logic        fas_inc;
  logic [7:0]  rd_data_d;
  sr2_t        sr2_set;

  // Two-stage capture of the asynchronous host pins, write data included
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      bus_s1_q <= 19'h007ff;
      bus_s2_q <= 19'h007ff;
    end else begin
      bus_s1_q <= {DATA_IN, CS_N, RD_N, WR_N, ADDR};
      bus_s2_q <= bus_s1_q;
    end
  end

  assign din_s  = bus_s2_q[18:11];
  assign addr_s = bus_s2_q[7:0];
  assign rd_act = !bus_s2_q[10] && !bus_s2_q[9];
  assign wr_act = !bus_s2_q[10] && !bus_s2_q[8];

  // Strobe edge history
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
    end
  end

  // Read data mux; shared bytes pack the FAS count around the small counts
  always_comb begin
    unique case (addr_s)
      ADDR_VIOL_HI:  rd_data_d = viol_q[15:8];
      ADDR_VIOL_LO:  rd_data_d = viol_q[7:0];
      ADDR_CRC_HI:   rd_data_d = {fas_q[11:6], crc_q[9:8]};
      ADDR_CRC_LO:   rd_data_d = crc_q[7:0];
      ADDR_EBIT_HI:  rd_data_d = {fas_q[5:0], ebit_q[9:8]};
      ADDR_EBIT_LO:  rd_data_d = ebit_q[7:0];
      ADDR_ALARM:    rd_data_d = ALARM_STATUS;
      ADDR_EVENT:    rd_data_d = sr2_q;
      ADDR_ALARM_IM: rd_data_d = alarm_interrupt_mask_q;
      ADDR_EVENT_IM: rd_data_d = event_interrupt_mask_q;
      default:       rd_data_d = 8'h00;
    endcase
  end

  // Data is captured once at the start of a read and held to its end
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      DATA_OUT   <= 8'h00;
      DATA_OE_N  <= 1'b1;
      rd_event_q <= 1'b0;
      rd_snap_q  <= FLAGS_RESET;
    end else begin
      DATA_OE_N <= !rd_act;
      if (rd_act && !rd_prev_q) begin
        DATA_OUT   <= rd_data_d;
        rd_event_q <= (addr_s == ADDR_EVENT);
        rd_snap_q  <= sr2_q;
      end
    end
  end

  // Mask registers take the write at the strobe's trailing edge
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      alarm_interrupt_mask_q <= MASK_RESET;
      event_interrupt_mask_q <= MASK_RESET;
    end else if (!wr_act && wr_prev_q) begin
      if (addr_s == ADDR_ALARM_IM) begin
        alarm_interrupt_mask_q <= din_s;
      end
      if (addr_s == ADDR_EVENT_IM) begin
        event_interrupt_mask_q <= din_s;
      end
    end
  end

  // Transmit clock pin: two flops, then a third for edge detection
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      transmit_clock_in_q <= 3'h0;
    end else begin
      transmit_clock_in_q <= {transmit_clock_in_q[1:0], TRANSMIT_CLOCK_IN};
    end
  end

  assign transmit_clock_in_edge  = transmit_clock_in_q[2] ^ transmit_clock_in_q[1];
  assign clock_lost = (loss_cnt_q == TX_LOSS_CYCLES);

  // Watchdog stops at the limit so loss stays asserted until an edge
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      loss_cnt_q <= 9'h000;
    end else if (transmit_clock_in_edge) begin
      loss_cnt_q <= 9'h000;
    end else if (!clock_lost) begin
      loss_cnt_q <= loss_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      TX_CLOCK_LOSS <= 1'b0;
    end else begin
      TX_CLOCK_LOSS <= clock_lost && CLOCK_LOSS_PIN_ENABLE;
    end
  end

  // Interval timer counts received frames, so it follows the line rate
  assign frame_limit   = SHORT_INTERVAL_SELECT ? FRAMES_PER_SHORT : FRAMES_PER_SECOND;
  assign interval_tick = FRAME_EV.rx_frame && (frame_cnt_q >= frame_limit - 13'h0001);

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      frame_cnt_q <= 13'h0000;
    end else if (interval_tick) begin
      frame_cnt_q <= 13'h0000;
    end else if (FRAME_EV.rx_frame) begin
      frame_cnt_q <= frame_cnt_q + 13'h0001;
    end
  end

  // Free-running 16-frame count stands in for CRC boundaries when CRC4 is off
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      mf_cnt_q <= 4'h0;
    end else if (FRAME_EV.rx_frame) begin
      mf_cnt_q <= mf_cnt_q + 4'h1;
    end
  end

  assign crc_mf_evt = CRC4_ENABLE ? FRAME_EV.rx_crc_mf
                                  : (FRAME_EV.rx_frame && mf_cnt_q == FRAMES_PER_MF);

  // Event sources for the second status register
  always_comb begin
    sr2_set.rx_cas_multiframe_flag = FRAME_EV.rx_cas_mf;
    sr2_set.rx_align_frame_flag    = FRAME_EV.rx_align;
    sr2_set.tx_multiframe_flag     = FRAME_EV.tx_mf;
    sr2_set.interval_timer_flag    = interval_tick;
    sr2_set.tx_align_frame_flag    = FRAME_EV.tx_align;
    sr2_set.tx_clock_loss_flag     = clock_lost;
    sr2_set.rx_crc_multiframe_flag = crc_mf_evt;
    sr2_set.tx_slip_flag           = FRAME_EV.tx_slip;
  end

  // Sticky flags clear after being read; a new event in that cycle wins
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sr2_q <= FLAGS_RESET;
    end else if (!rd_act && rd_prev_q && rd_event_q) begin
      sr2_q <= (sr2_q & ~rd_snap_q) | sr2_set;
    end else begin
      sr2_q <= sr2_q | sr2_set;
    end
  end

  // Interrupt request from both status registers through their masks
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      INT_REQ <= 1'b0;
    end else begin
      INT_REQ <= |(ALARM_STATUS & alarm_interrupt_mask_q) || |(sr2_q & event_interrupt_mask_q);
    end
  end

  // Increment qualifiers for the four error counters
  assign viol_inc = VIOLATION_TYPE_SELECT ? ERR_EV.code_viol
                  : (ERR_EV.bpv && !(RX_HDB3_ENABLE && ERR_EV.hdb3_codeword));
  assign crc_inc  = ERR_EV.crc_err && !SYNC_STATE.fas_loss && !SYNC_STATE.crc_loss;
  assign ebit_inc = ERR_EV.ebit_strobe && !ERR_EV.ebit_value
                  && !SYNC_STATE.fas_loss && !SYNC_STATE.crc_loss;
  assign fas_inc  = ERR_EV.fas_err && !ALARM_STATUS.rx_sync_loss_flag
                  && !SYNC_STATE.fas_search && !SYNC_STATE.cas_search
                  && !SYNC_STATE.crc_search;

  // Accumulators restart each interval; the boundary cycle's error is kept
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      viol_acc_q <= 16'h0000;
    end else if (interval_tick) begin
      viol_acc_q <= {15'h0000, viol_inc};
    end else if (viol_inc && viol_acc_q != VIOL_MAX) begin
      viol_acc_q <= viol_acc_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      crc_acc_q <= 10'h000;
    end else if (interval_tick) begin
      crc_acc_q <= {9'h000, crc_inc};
    end else if (crc_inc && crc_acc_q != CRC_MAX) begin
      crc_acc_q <= crc_acc_q + 10'h001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ebit_acc_q <= 10'h000;
    end else if (interval_tick) begin
      ebit_acc_q <= {9'h000, ebit_inc};
    end else if (ebit_inc && ebit_acc_q != EBIT_MAX) begin
      ebit_acc_q <= ebit_acc_q + 10'h001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      fas_acc_q <= 12'h000;
    end else if (interval_tick) begin
      fas_acc_q <= {11'h000, fas_inc};
    end else if (fas_inc && fas_acc_q != FAS_MAX) begin
      fas_acc_q <= fas_acc_q + 12'h001;
    end
  end

  // Host-visible totals of the previous interval, all latched together
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      viol_q <= 16'h0000;
      crc_q  <= 10'h000;
      ebit_q <= 10'h000;
      fas_q  <= 12'h000;
    end else if (interval_tick) begin
      viol_q <= viol_acc_q;
      crc_q  <= crc_acc_q;
      ebit_q <= ebit_acc_q;
      fas_q  <= fas_acc_q;
    end
  end

  a_viol_saturate: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (viol_acc_q == VIOL_MAX && viol_inc && !interval_tick) |=> viol_acc_q == VIOL_MAX)
    else $error("violation count wrapped");

  a_code_viol_count: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (VIOLATION_TYPE_SELECT && ERR_EV.code_viol && !interval_tick && viol_acc_q != VIOL_MAX)
    |=> viol_acc_q == $past(viol_acc_q) + 16'h0001)
    else $error("code violation not counted");

  a_hdb3_excluded: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (!VIOLATION_TYPE_SELECT && RX_HDB3_ENABLE && ERR_EV.hdb3_codeword && !interval_tick)
    |=> $stable(viol_acc_q))
    else $error("codeword violation counted");

  a_crc_hold_loss: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (SYNC_STATE.crc_loss && !interval_tick) |=> $stable(crc_acc_q) && $stable(ebit_acc_q))
    else $error("crc or ebit counted during sync loss");

  a_ebit_count: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (ERR_EV.ebit_strobe && !ERR_EV.ebit_value && !SYNC_STATE.fas_loss
     && !SYNC_STATE.crc_loss && !interval_tick && ebit_acc_q != EBIT_MAX)
    |=> ebit_acc_q == $past(ebit_acc_q) + 10'h001)
    else $error("zero E-bit not counted");

  a_fas_search_hold: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (SYNC_STATE.fas_search && !interval_tick) |=> $stable(fas_acc_q))
    else $error("fas counted during search");

  a_latch_totals: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    interval_tick |=> viol_q == $past(viol_acc_q) && crc_q == $past(crc_acc_q)
                      && ebit_q == $past(ebit_acc_q) && fas_q == $past(fas_acc_q))
    else $error("totals not latched at interval");

  a_clock_loss_flag: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (!transmit_clock_in_edge && loss_cnt_q == TX_LOSS_CYCLES - 9'h001)
    |=> ##1 sr2_q.tx_clock_loss_flag && TX_CLOCK_LOSS == $past(CLOCK_LOSS_PIN_ENABLE))
    else $error("transmit clock loss not reported");

  a_slip_sticky: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    FRAME_EV.tx_slip |=> sr2_q.tx_slip_flag)
    else $error("transmit slip lost");

  a_interrupt_req: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    ((sr2_q & event_interrupt_mask_q) != 8'h00) |=> INT_REQ)
    else $error("enabled event did not interrupt");

endmodule

//--- bench/e1_host_model.sv
`timescale 1ns/1ps

// Host processor on the parallel port, pins move 1 ns after an edge
module e1_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [7:0]      addr,
  output logic [7:0]      data_in
);
  logic [7:0] wdat = 8'h00;
  logic       wact = 1'h0;
  logic       oe_seen = 1'h1;

  // Idle bus shows inverted last write, so stale data never passes
  assign data_in = !data_oe_n ? data_out : (wact ? wdat : ~wdat);

  // Strobes idle high from time zero
  initial begin
    cs_n = 1'h1;
    rd_n = 1'h1;
    wr_n = 1'h1;
    addr = 8'h00;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Strobe held five edges, data taken at the last, then released
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    step(2);
    cs_n = 1'h0;
    rd_n = 1'h0;
    repeat (5) @(posedge clk);
    d = data_out;
    oe_seen = data_oe_n;
    #1;
    cs_n = 1'h1;
    rd_n = 1'h1;
    step(4);
  endtask

  // Address and data stay put well past the strobe's release
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    wdat = v;
    wact = 1'h1;
    step(2);
    cs_n = 1'h0;
    wr_n = 1'h0;
    step(4);
    cs_n = 1'h1;
    wr_n = 1'h1;
    step(4);
    wact = 1'h0;
  endtask
endmodule

//--- bench/e1_status_and_perf_counters_tb.sv
`timescale 1ns/1ps

module e1_status_and_perf_counters_tb;
  import e1_perf_pkg::*;
  logic       clk_sys = 1'h0;
  logic       nrst = 1'h0;
  logic       tx_clk = 1'h0;
  logic       tx_clk_run = 1'h1;
  frame_ev_t  fe = '0;
  err_ev_t    ee = '0;
  sync_t      ss = '0;
  sr1_t       al = '0;
  logic       crc4_en = 1'h1;
  logic       short_sel = 1'h0;
  logic       vtype = 1'h0;
  logic       hdb3_en = 1'h1;
  logic       pin_en = 1'h1;
  logic       cs_n, rd_n, wr_n, oe_n, loss, irq;
  logic [7:0] addr, din, dout, rdat;
  int         error_cnt = 0;
  int         total_checks = 0;
  logic [7:0] regs[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h16, 8'h17,
                           8'h08, 8'h20};

  always #5 clk_sys = ~clk_sys;

  // Transmit clock near 2 MHz; stopping it provokes the loss detector
  always #244 if (tx_clk_run) tx_clk = ~tx_clk;

  e1_host_model host_i (.clk(clk_sys), .data_out(dout), .data_oe_n(oe_n), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(din));

  e1_status_perf e1_status_perf_i (.CLK_SYS(clk_sys), .NRST(nrst), .CS_N(cs_n), .RD_N(rd_n),
    .WR_N(wr_n), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(oe_n),
    .TRANSMIT_CLOCK_IN(tx_clk), .FRAME_EV(fe), .ERR_EV(ee), .SYNC_STATE(ss),
    .ALARM_STATUS(al), .CRC4_ENABLE(crc4_en), .SHORT_INTERVAL_SELECT(short_sel),
    .VIOLATION_TYPE_SELECT(vtype), .RX_HDB3_ENABLE(hdb3_en),
    .CLOCK_LOSS_PIN_ENABLE(pin_en), .TX_CLOCK_LOSS(loss), .INT_REQ(irq));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_i.rd(a, rdat);
    chk8($sformatf("register %h", a), exp, rdat);
  endtask

  // Single boundary strobe, then time for flag and request to settle
  task automatic pulse_fe(input frame_ev_t p);
    fe = p;
    tick(1);
    fe = '0;
    tick(3);
  endtask

  task automatic frames(input int n);
    fe = 7'h01;
    tick(n);
    fe = '0;
    tick(3);
  endtask

  task automatic err(input err_ev_t e, input sync_t s, input sr1_t a, input int n);
    ee = e;
    ss = s;
    al = a;
    tick(n);
    ee = '0;
    ss = '0;
    al = '0;
    tick(1);
  endtask

  task automatic t_reset;
    foreach (regs[i]) rchk(regs[i], 8'h00);
    chk1("data enable in read", 1'h0, host_i.oe_seen);
    chk1("data enable idle", 1'h1, oe_n);
    chk1("interrupt", 1'h0, irq);
    $display("test reset done");
  endtask

  // Masks read back; the status register ignores writes
  task automatic t_masks;
    host_i.wr(8'h16, 8'ha5);
    host_i.wr(8'h17, 8'h5a);
    host_i.wr(8'h07, 8'hff);
    rchk(8'h16, 8'ha5);
    rchk(8'h17, 8'h5a);
    rchk(8'h07, 8'h00);
    host_i.wr(8'h16, 8'h00);
    host_i.wr(8'h17, 8'h00);
    $display("test masks done");
  endtask

  task automatic t_flags;
    frame_ev_t  evs[6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02};
    logic [7:0] exps[6] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h02, 8'h01};
    for (int i = 0; i < 6; i++) begin
      pulse_fe(evs[i]);
      rchk(8'h07, exps[i]);
    end
    rchk(8'h07, 8'h00);
    $display("test flags done");
  endtask

  task automatic t_irq;
    host_i.wr(8'h17, 8'h01);
    pulse_fe(7'h02);
    chk1("slip interrupt", 1'h1, irq);
    host_i.rd(8'h07, rdat);
    chk1("interrupt after clear", 1'h0, irq);
    host_i.wr(8'h17, 8'hfe);
    pulse_fe(7'h02);
    chk1("masked slip", 1'h0, irq);
    rchk(8'h07, 8'h01);
    host_i.wr(8'h16, 8'h01);
    al = 8'h01;
    tick(3);
    chk1("alarm interrupt", 1'h1, irq);
    host_i.wr(8'h16, 8'hfe);
    chk1("masked alarm", 1'h0, irq);
    rchk(8'h06, 8'h01);
    al = '0;
    host_i.wr(8'h16, 8'h00);
    host_i.wr(8'h17, 8'h00);
    $display("test interrupt done");
  endtask

  // Without CRC4, sixteen frames still hold one multiframe mark
  task automatic t_crc_free;
    crc4_en = 1'h0;
    repeat (16) pulse_fe(7'h01);
    host_i.rd(8'h07, rdat);
    chk8("crc multiframe", 8'h02, rdat & 8'h02);
    crc4_en = 1'h1;
    $display("test free multiframe done");
  endtask

  task automatic t_counts;
    host_i.wr(8'h17, 8'h10);
    // One-second mode; sixteen frames already went by in the multiframe test
    frames(7983);
    chk1("second early", 1'h0, irq);
    frames(1);
    chk1("second due", 1'h1, irq);
    host_i.rd(8'h07, rdat);
    short_sel = 1'h1;
    for (int i = 0; i < 600 && irq !== 1'h1; i++) pulse_fe(7'h01);
    chk1("interval sync", 1'h1, irq);
    host_i.rd(8'h07, rdat);
    err(7'h40, 5'h00, 8'h00, 5);
    err(7'h60, 5'h00, 8'h00, 2);
    err(7'h10, 5'h00, 8'h00, 3);
    err(7'h08, 5'h00, 8'h00, 4);
    err(7'h08, 5'h10, 8'h00, 1);
    err(7'h08, 5'h08, 8'h00, 1);
    err(7'h08, 5'h02, 8'h00, 1);
    err(7'h04, 5'h00, 8'h00, 3);
    err(7'h06, 5'h00, 8'h00, 2);
    err(7'h04, 5'h10, 8'h00, 1);
    err(7'h01, 5'h00, 8'h00, 6);
    err(7'h01, 5'h04, 8'h00, 1);
    err(7'h01, 5'h02, 8'h00, 1);
    err(7'h01, 5'h01, 8'h00, 1);
    err(7'h01, 5'h00, 8'h01, 1);
    rchk(8'h01, 8'h00);
    frames(499);
    chk1("interval early", 1'h0, irq);
    frames(1);
    chk1("interval due", 1'h1, irq);
    rchk(8'h00, 8'h00);
    rchk(8'h01, 8'h05);
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h05);
    rchk(8'h04, 8'h18);
    rchk(8'h05, 8'h03);
    // Code violations counted even through loss of sync
    vtype = 1'h1;
    err(7'h10, 5'h00, 8'h00, 2);
    err(7'h10, 5'h10, 8'h01, 1);
    err(7'h40, 5'h00, 8'h00, 4);
    frames(500);
    rchk(8'h01, 8'h03);
    rchk(8'h03, 8'h00);
    // Every counter driven past its top in one interval
    vtype = 1'h0;
    err(7'h4d, 5'h00, 8'h00, 65540);
    frames(500);
    for (int i = 0; i < 6; i++) rchk(regs[i], 8'hff);
    $display("test counters done");
  endtask

  task automatic t_clock_loss;
    host_i.rd(8'h07, rdat);
    tx_clk_run = 1'h0;
    tick(350);
    chk1("loss early", 1'h0, loss);
    tick(60);
    chk1("loss pin", 1'h1, loss);
    host_i.rd(8'h07, rdat);
    chk8("loss flag", 8'h04, rdat & 8'h04);
    pin_en = 1'h0;
    tick(3);
    chk1("loss pin disabled", 1'h0, loss);
    tx_clk_run = 1'h1;
    $display("test clock loss done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Run is near 80k cycles; the limit leaves margin yet stays under 100k
  initial begin
    #950000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    nrst = 1'h1;
    tick(2);
    t_reset();
    t_masks();
    t_flags();
    t_irq();
    t_crc_free();
    t_counts();
    t_clock_loss();
    report_and_stop();
  end
endmodule
